/* src/muting_params.svh */
// Constants of the muting override and error block: timing, offsets, fields, reset values.
// Assumes inclusion by bare name from every file that needs a figure.
// What this block does
// - Override starts: sensor on, curtain blocked, override on
// - No override start at start of operation
// - Override ends: sensors off, timeout, override off
// - Override end with curtain blocked drops enable
// - Run start clears faults, timers; outputs follow inputs
// - Four muting modes, parallel default, mode picks sensors
// - Synchronization time 30 ms to 3 s, default 3 s
// - Synchronization spans signals 11-12 or 21-22
// - Curtain pair equivalent NC/NC or complementary NC/NO
// - Override input single, dual, complementary or unused
// - Discrepancy times 10-500 ms, default 30, 0 off
// - Max override and muting time, 60 s default
// - Synchronization error on late pair, never position
// - Bidirectional: entry checks 11-12, exit 21-22
// - Sequence error on wrong sensor order
// - Position mode: curtain off with 11 normal
// - Sequence checking starts after all sensors off
// - Sync or sequence error plus blocked curtain faults
// - Each pair reports discrepancy; either forces fault
// - Discrepancy clears on pair reactivation or run start
// - Sync and sequence errors clear on muting, run
`ifndef MUTING_PARAMS_SVH
`define MUTING_PARAMS_SVH

// Clock rate and controller cycle
`define CLK_MHZ 100
`define TICK_TIME_MS 10
`define TICK_CYCLES_DEFAULT (`TICK_TIME_MS * 1000 * `CLK_MHZ)
// Coarse timer step in ms, and in controller cycles
`define LONG_STEP_MS 500
`define LONG_STEP_TICKS 14'((`LONG_STEP_MS) / (`TICK_TIME_MS))

// Register byte offsets
`define ADDR_CTRL 5'h00
`define ADDR_SYNC_TIME 5'h04
`define ADDR_DISC_TIME 5'h08
`define ADDR_MAX_TIME 5'h0c
`define ADDR_STATUS 5'h10

// Control fields
`define CTRL_RUN 0
`define CTRL_MODE_LO 1
`define CTRL_LC_COMP 3
`define CTRL_OVR_LO 4
`define DISC_OVR_LO 8
`define MAX_MUTE_LO 8

// Reset values
`define RST_CTRL 6'h02
`define RST_SYNC_TIME 9'h12c
`define RST_DISC_TIME 6'h03
`define RST_MAX_TIME 8'h78

`endif

/* src/muting_pkg.sv */
// Types of the muting override and error block.
// Assumes nothing outside itself.
package muting_pkg;
   // Muting modes
   typedef enum logic [1:0] {
      MODE_POSITION = 2'h0,
      MODE_PARALLEL = 2'h1,
      MODE_SEQ_FWD = 2'h2,
      MODE_SEQ_BI = 2'h3
   } mode_t;
   // Override input kinds
   typedef enum logic [1:0] {
      OVR_UNUSED = 2'h0,
      OVR_SINGLE = 2'h1,
      OVR_DUAL_EQ = 2'h2,
      OVR_DUAL_COMP = 2'h3
   } ovr_type_t;
   // Output state
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_NORMAL = 4'h2,
      ST_MUTING = 4'h4,
      ST_OVERRIDE = 4'h8
   } state_t;
   // Sensor sequence monitor
   typedef enum logic [3:0] {
      SQ_OFF = 4'h1,
      SQ_ARMED = 4'h2,
      SQ_ENTRY = 4'h4,
      SQ_EXIT = 4'h8
   } seq_t;
   // Whole state of the top module
   typedef struct packed {
      state_t st;
      seq_t sq;
      logic exit_dir;
      logic first;
      logic ovr_armed;
      logic run_prev;
      logic [3:0] prev_ms;
      logic [19:0] div;
      logic tick;
      logic [13:0] sync_cnt;
      logic [13:0] mute_cnt;
      logic [13:0] ovr_cnt;
      logic oe;
      logic mute;
      logic ovr;
      logic sync_err;
      logic seq_err;
      logic fault;
      logic [5:0] ctrl;
      logic [8:0] sync_time;
      logic [5:0] disc_lc;
      logic [5:0] disc_ovr;
      logic [7:0] max_ovr;
      logic [7:0] max_mute;
      logic waitreq;
      logic [31:0] rdata;
   } mute_state_t;
endpackage

/* src/pin_sync.sv */
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to clk.
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pins in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // Both stages
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_state_t;

   sync_state_t r; // Current stages
   sync_state_t next_r; // Next stages

   // First stage feeds only the second
   always_comb begin
      next_r.s1 = d;
      next_r.s2 = r.s1;
   end

   // Stage registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q = r.s2;
endmodule

/* src/pair_monitor.sv */
// Discrepancy monitor for one dual-channel input pair.
// Assumes tick is a one-cycle controller-cycle pulse and inputs are synchronised.
`timescale 1ns/1ps
module pair_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Controller cycle and run start
   input wire logic tick,
   input wire logic clear,
   // Channels and setup
   input wire logic in_a,
   input wire logic in_b,
   input wire logic complementary,
   input wire logic [5:0] limit,
   // Results
   output logic active,
   output logic err
);
   // Monitor state
   typedef struct packed {
      logic [5:0] cnt;
      logic err;
      logic active;
      logic good_prev;
   } pair_state_t;

   pair_state_t r; // Current state
   pair_state_t next_r; // Next state
   logic good; // Pair agrees and is active
   logic disc; // Channels disagree
   logic set; // Discrepancy outlasted limit
   logic clr; // Reactivation or run start

   // Discrepancy count and sticky error
   always_comb begin
      next_r = r;
      good = in_a & (complementary ? ~in_b : in_b);
      disc = in_a ^ in_b ^ complementary;
      set = 1'b0;
      clr = 1'b0;
      if (tick) begin
         clr = clear | (good & ~r.good_prev);
         if (disc && limit != 6'h00 && !clr) begin
            next_r.cnt = (r.cnt == 6'h3f) ? r.cnt : r.cnt + 6'h01;
         end else begin
            next_r.cnt = 6'h00;
         end
         set = disc && limit != 6'h00 && next_r.cnt >= limit;
         next_r.err = set | (r.err & ~clr);
         next_r.good_prev = good;
         next_r.active = good & ~next_r.err;
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign active = r.active;
   assign err = r.err;
endmodule

/* src/muting_override.sv */
// Muting override and error handling, evaluated once per controller cycle.
// Assumes pins asynchronous to MCLK and an Avalon-MM master on the register port.
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "muting_params.svh"
module muting_override
   import muting_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYCLES_DEFAULT
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Avalon-MM slave
   input wire logic [4:0] ADDRESS,
   input wire logic READ,
   input wire logic WRITE,
   input wire logic [31:0] WRITEDATA,
   output logic [31:0] READDATA,
   output logic WAITREQUEST,
   // Light-curtain pair and muting sensors
   input wire logic LC_IN1,
   input wire logic LC_IN2,
   input wire logic MS11,
   input wire logic MS12,
   input wire logic MS21,
   input wire logic MS22,
   // Override pair
   input wire logic OVR_IN1,
   input wire logic OVR_IN2,
   // Safety outputs
   output logic OUTPUT_ENABLE,
   output logic MUTING_STATUS,
   output logic OVERRIDE_STATUS,
   output logic SYNC_ERROR,
   output logic SEQ_ERROR,
   output logic LC_DISC_ERROR,
   output logic OVR_DISC_ERROR,
   output logic FAULT_PRESENT
);
   mute_state_t r; // Current state
   mute_state_t next_r; // Next state
   logic [7:0] pins; // Synchronised pins
   logic [3:0] ms; // Sensors 22,21,12,11
   logic [3:0] rise; // Sensors just turned on
   logic lc_active; // Curtain pair active
   logic lc_err; // Curtain discrepancy
   logic ovr_active; // Override pair active
   logic ovr_err; // Override discrepancy
   logic ovr_on; // Override asserted
   logic run; // Run mode requested
   logic run_start; // First cycle of run
   mode_t mode; // Selected mode
   ovr_type_t otype; // Override kind
   logic ovr_dual; // Override is dual
   logic disc_any; // Any discrepancy
   logic any_ms; // Some sensor on
   logic mute_req; // Normal muting sequence met
   logic mute_end; // Mode end condition
   logic [13:0] ovr_limit; // Max override in cycles
   logic [13:0] mute_limit; // Max muting in cycles
   logic [31:0] rd; // Read mux

   // Pin synchronisers
   pin_sync #(.W(8)) u_sync (
      .clk(MCLK),
      .rst(RST),
      .d({OVR_IN2, OVR_IN1, MS22, MS21, MS12, MS11, LC_IN2, LC_IN1}),
      .q(pins)
   );

   // Configuration decode
   assign run = r.ctrl[`CTRL_RUN];
   assign mode = mode_t'(r.ctrl[`CTRL_MODE_LO +: 2]);
   assign otype = ovr_type_t'(r.ctrl[`CTRL_OVR_LO +: 2]);
   assign ovr_dual = (otype == OVR_DUAL_EQ) || (otype == OVR_DUAL_COMP);
   assign run_start = r.tick & run & ~r.run_prev;

   // Curtain pair monitor
   pair_monitor u_lc (
      .clk(MCLK),
      .rst(RST),
      .tick(r.tick),
      .clear(run_start),
      .in_a(pins[0]),
      .in_b(pins[1]),
      .complementary(r.ctrl[`CTRL_LC_COMP]),
      .limit(r.disc_lc),
      .active(lc_active),
      .err(lc_err)
   );

   // Override pair monitor, check off unless dual
   pair_monitor u_ovr (
      .clk(MCLK),
      .rst(RST),
      .tick(r.tick),
      .clear(run_start),
      .in_a(pins[6]),
      .in_b(pins[7]),
      .complementary(otype == OVR_DUAL_COMP),
      .limit(ovr_dual ? r.disc_ovr : 6'h00),
      .active(ovr_active),
      .err(ovr_err)
   );

   // Derived input terms
   always_comb begin
      ms = pins[5:2];
      rise = ms & ~r.prev_ms;
      any_ms = |ms;
      disc_any = lc_err | (ovr_dual & ovr_err);
      case (otype)
         OVR_SINGLE: ovr_on = pins[6];
         OVR_DUAL_EQ, OVR_DUAL_COMP: ovr_on = ovr_active;
         default: ovr_on = 1'b0;
      endcase
      ovr_limit = {6'h00, r.max_ovr} * `LONG_STEP_TICKS;
      mute_limit = {6'h00, r.max_mute} * `LONG_STEP_TICKS;
      case (mode)
         MODE_PARALLEL: mute_end = ~ms[0] | ~ms[1];
         MODE_POSITION: mute_end = ~ms[0];
         default: mute_end = r.exit_dir ? ~(ms[1] | ms[2] | ms[3]) : ~(ms[0] | ms[1] | ms[2]);
      endcase
   end

   // Register read mux
   always_comb begin
      case (ADDRESS)
         `ADDR_CTRL: rd = {26'h0, r.ctrl};
         `ADDR_SYNC_TIME: rd = {23'h0, r.sync_time};
         `ADDR_DISC_TIME: rd = {18'h0, r.disc_ovr, 2'h0, r.disc_lc};
         `ADDR_MAX_TIME: rd = {16'h0, r.max_mute, r.max_ovr};
         `ADDR_STATUS: rd = {20'h0, r.st, r.fault, ovr_err, lc_err, r.seq_err,
                             r.sync_err, r.ovr, r.mute, r.oe};
         default: rd = 32'h0;
      endcase
   end

   // Divider, bus slave and per-cycle evaluation
   always_comb begin
      next_r = r;
      mute_req = 1'b0;
      // Controller cycle divider
      next_r.tick = 1'b0;
      if (r.div == 20'(TICK_CYCLES - 1)) begin
         next_r.div = 20'h0;
         next_r.tick = 1'b1;
      end else begin
         next_r.div = r.div + 20'h1;
      end
      // One wait cycle per access
      next_r.waitreq = 1'b1;
      if ((READ | WRITE) & r.waitreq) begin
         next_r.waitreq = 1'b0;
         next_r.rdata = rd;
      end
      if (WRITE & ~r.waitreq) begin
         case (ADDRESS)
            `ADDR_CTRL: next_r.ctrl = WRITEDATA[5:0];
            `ADDR_SYNC_TIME: next_r.sync_time = WRITEDATA[8:0];
            `ADDR_DISC_TIME: begin
               next_r.disc_lc = WRITEDATA[5:0];
               next_r.disc_ovr = WRITEDATA[`DISC_OVR_LO +: 6];
            end
            `ADDR_MAX_TIME: begin
               next_r.max_ovr = WRITEDATA[7:0];
               next_r.max_mute = WRITEDATA[`MAX_MUTE_LO +: 8];
            end
            default: begin
            end
         endcase
      end
      // Evaluation once per controller cycle
      if (r.tick) begin
         next_r.run_prev = run;
         next_r.prev_ms = ms;
         if (!run) begin
            // Idle: enable, muting, override and fault off; sync and sequence errors kept
            next_r.st = ST_IDLE;
            next_r.sq = SQ_OFF;
            next_r.oe = 1'b0;
            next_r.mute = 1'b0;
            next_r.ovr = 1'b0;
            next_r.fault = 1'b0;
         end else if (run_start) begin
            // Fresh start from current inputs
            next_r.st = ST_NORMAL;
            next_r.sq = any_ms ? SQ_OFF : SQ_ARMED;
            next_r.first = 1'b1;
            next_r.ovr_armed = 1'b0;
            next_r.sync_cnt = 14'h0;
            next_r.mute_cnt = 14'h0;
            next_r.ovr_cnt = 14'h0;
            next_r.sync_err = 1'b0;
            next_r.seq_err = 1'b0;
            next_r.fault = 1'b0;
            next_r.mute = 1'b0;
            next_r.ovr = 1'b0;
            next_r.oe = pins[0] & (r.ctrl[`CTRL_LC_COMP] ? ~pins[1] : pins[1]);
         end else begin
            next_r.first = 1'b0;
            // Override must be seen off after start
            if (!ovr_on && !r.first) begin
               next_r.ovr_armed = 1'b1;
            end
            // Sequence and synchronization monitor
            if (r.st == ST_NORMAL) begin
               case (r.sq)
                  SQ_OFF: begin
                     if (!any_ms) begin
                        next_r.sq = SQ_ARMED;
                     end
                  end
                  SQ_ARMED: begin
                     if (mode == MODE_POSITION) begin
                        mute_req = ms[0];
                     end else if (rise == 4'b0001) begin
                        next_r.sq = SQ_ENTRY;
                        next_r.sync_cnt = 14'h0;
                     end else if (mode == MODE_SEQ_BI && rise == 4'b1000) begin
                        next_r.sq = SQ_EXIT;
                        next_r.sync_cnt = 14'h0;
                     end else if (rise != 4'b0000) begin
                        next_r.seq_err = 1'b1;
                        next_r.sq = SQ_OFF;
                     end
                  end
                  SQ_ENTRY: begin
                     next_r.sync_cnt = r.sync_cnt + 14'h1;
                     if (!ms[0] || ms[2] || ms[3]) begin
                        next_r.seq_err = 1'b1;
                        next_r.sq = SQ_OFF;
                     end else if (next_r.sync_cnt > {5'h0, r.sync_time}) begin
                        next_r.sync_err = 1'b1;
                        next_r.sq = SQ_OFF;
                     end else if (ms[1]) begin
                        mute_req = 1'b1;
                        next_r.exit_dir = 1'b0;
                     end
                  end
                  SQ_EXIT: begin
                     next_r.sync_cnt = r.sync_cnt + 14'h1;
                     if (!ms[3] || ms[0] || ms[1]) begin
                        next_r.seq_err = 1'b1;
                        next_r.sq = SQ_OFF;
                     end else if (next_r.sync_cnt > {5'h0, r.sync_time}) begin
                        next_r.sync_err = 1'b1;
                        next_r.sq = SQ_OFF;
                     end else if (ms[2]) begin
                        mute_req = 1'b1;
                        next_r.exit_dir = 1'b1;
                     end
                  end
                  default: next_r.sq = SQ_OFF;
               endcase
            end
            // Output state machine
            case (r.st)
               ST_NORMAL: begin
                  next_r.oe = lc_active & ~disc_any;
                  if (mute_req && lc_active && !disc_any) begin
                     next_r.st = ST_MUTING;
                     next_r.sq = SQ_OFF;
                     next_r.mute = 1'b1;
                     next_r.oe = 1'b1;
                     next_r.mute_cnt = 14'h0;
                     next_r.sync_err = 1'b0;
                     next_r.seq_err = 1'b0;
                  end else if (r.ovr_armed && any_ms && !lc_active && ovr_on && !disc_any) begin
                     next_r.st = ST_OVERRIDE;
                     next_r.sq = SQ_OFF;
                     next_r.ovr = 1'b1;
                     next_r.mute = 1'b1;
                     next_r.oe = 1'b1;
                     next_r.ovr_cnt = 14'h0;
                  end
               end
               ST_MUTING: begin
                  next_r.mute_cnt = r.mute_cnt + 14'h1;
                  if (disc_any) begin
                     next_r.st = ST_NORMAL;
                     next_r.mute = 1'b0;
                     next_r.oe = 1'b0;
                  end else if (mute_end || (r.max_mute != 8'h00 && next_r.mute_cnt >= mute_limit)) begin
                     next_r.st = ST_NORMAL;
                     next_r.mute = 1'b0;
                     next_r.oe = lc_active;
                  end
               end
               ST_OVERRIDE: begin
                  next_r.ovr_cnt = r.ovr_cnt + 14'h1;
                  if (!any_ms || next_r.ovr_cnt >= ovr_limit || !ovr_on || disc_any) begin
                     next_r.st = ST_NORMAL;
                     next_r.ovr = 1'b0;
                     next_r.mute = 1'b0;
                     next_r.oe = lc_active & ~disc_any;
                  end
               end
               default: begin
                  next_r.st = ST_NORMAL;
                  next_r.oe = 1'b0;
               end
            endcase
            // Blocked curtain with a pending error is a fault
            if ((next_r.sync_err || next_r.seq_err) && !lc_active && next_r.st == ST_NORMAL) begin
               next_r.oe = 1'b0;
            end
            next_r.fault = disc_any | ((next_r.sync_err | next_r.seq_err) & ~lc_active);
         end
      end
   end

   // State register
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.sq <= SQ_OFF;
         r.ctrl <= `RST_CTRL;
         r.sync_time <= `RST_SYNC_TIME;
         r.disc_lc <= `RST_DISC_TIME;
         r.disc_ovr <= `RST_DISC_TIME;
         r.max_ovr <= `RST_MAX_TIME;
         r.max_mute <= `RST_MAX_TIME;
         r.waitreq <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // Outputs from flip-flops
   assign READDATA = r.rdata;
   assign WAITREQUEST = r.waitreq;
   assign OUTPUT_ENABLE = r.oe;
   assign MUTING_STATUS = r.mute;
   assign OVERRIDE_STATUS = r.ovr;
   assign SYNC_ERROR = r.sync_err;
   assign SEQ_ERROR = r.seq_err;
   assign LC_DISC_ERROR = lc_err;
   assign OVR_DISC_ERROR = ovr_err;
   assign FAULT_PRESENT = r.fault;
endmodule

/* test/lc_partner.sv */
// Far-side model: light-curtain pair, muting sensors and override switch.
// Assumes the bench moves its controls just after MCLK rises.
`timescale 1ns/1ps
module lc_partner (
   // Controls from the bench
   input wire logic clear,
   input wire logic comp,
   input wire logic lc_brk,
   input wire logic ovr_on,
   input wire logic ovr_brk,
   input wire logic [3:0] sens,
   // Pins toward the block
   output logic lc1,
   output logic lc2,
   output logic [3:0] ms,
   output logic ov1,
   output logic ov2
);
   // Curtain pair, second channel inverted when complementary
   assign lc1 = clear;
   assign lc2 = (comp ? ~clear : clear) ^ lc_brk;
   // Sensors high while detecting
   assign ms = sens;
   // Override pair, equivalent normally-open
   assign ov1 = ovr_on;
   assign ov2 = ovr_on ^ ovr_brk;
endmodule

/* test/muting_override_asserts.sv */
// Checker of the override and error block, bound to its top ports.
// Assumes the bench runs TICK_CYCLES at 4, so bounds are in MCLK cycles.
`timescale 1ns/1ps
module muting_override_asserts #(
   parameter int TICK_CYCLES = 4
) (
   // Clock, reset, bus handshake
   input wire logic MCLK,
   input wire logic RST,
   input wire logic READ,
   input wire logic WRITE,
   input wire logic WAITREQUEST,
   // Pins
   input wire logic LC_IN1,
   input wire logic MS11,
   input wire logic MS12,
   input wire logic MS21,
   input wire logic MS22,
   input wire logic OVR_IN1,
   // Safety outputs
   input wire logic OUTPUT_ENABLE,
   input wire logic MUTING_STATUS,
   input wire logic OVERRIDE_STATUS,
   input wire logic LC_DISC_ERROR,
   input wire logic OVR_DISC_ERROR,
   input wire logic FAULT_PRESENT
);
   localparam int LIM = 4 * TICK_CYCLES; // Settling bound
   logic [7:0] blk; // Cycles curtain channel low
   logic [7:0] ovoff; // Cycles override channel low
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RST);
   // Saturating low-time counters
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         blk <= 8'h00;
         ovoff <= 8'h00;
      end else begin
         blk <= LC_IN1 ? 8'h00 : (blk == 8'hff ? blk : blk + 8'h01);
         ovoff <= OVR_IN1 ? 8'h00 : (ovoff == 8'hff ? ovoff : ovoff + 8'h01);
      end
   end
   sequence req_s;
      (READ || WRITE) && WAITREQUEST;
   endsequence
   sequence sens_off_s;
      (!MS11 && !MS12 && !MS21 && !MS22) [*8];
   endsequence
   AST_WAIT_ONE: assert property (req_s |=> !WAITREQUEST) else $error("no answer one cycle after request");
   AST_WAIT_PULSE: assert property (!WAITREQUEST |=> WAITREQUEST) else $error("wait low too long");
   AST_OVR_MUTE: assert property (OVERRIDE_STATUS |-> MUTING_STATUS && OUTPUT_ENABLE)
      else $error("override without muting and enable");
   AST_DISC_FAULT: assert property ((LC_DISC_ERROR || OVR_DISC_ERROR) |-> ##[0:6] (FAULT_PRESENT && !OUTPUT_ENABLE))
      else $error("discrepancy without fault");
   AST_SENS_OFF: assert property (sens_off_s |=> !OVERRIDE_STATUS)
      else $error("override with sensors off");
   AST_OVR_PIN_OFF: assert property (ovoff >= LIM |-> !OVERRIDE_STATUS)
      else $error("override with input off");
   AST_BLOCKED_OE: assert property (blk >= LIM && !MUTING_STATUS |-> !OUTPUT_ENABLE)
      else $error("enable with curtain blocked");
   AST_MUTE_OE: assert property (MUTING_STATUS && !FAULT_PRESENT |-> OUTPUT_ENABLE)
      else $error("muting without enable");
endmodule

/* test/muting_override_tb.sv */
// Self-checking bench of the override and error block.
// Assumes a short controller cycle of 4 MCLK and the far-side model.
`timescale 1ns/1ps
module muting_override_tb;
   localparam int TK = 4; // Short controller cycle
   logic mclk, rst, rd, wr, wait_req, lc1, lc2, ov1, ov2;
   logic [4:0] addr;
   logic [31:0] wdata, rdata, got;
   logic [3:0] ms, sens;
   logic oe, mute, ovr, sync_err, seq_err, lc_disc, ovr_disc, fault;
   logic clear, comp, lc_brk, ovr_on, ovr_brk;
   int err_count, samples_checked, n;
   logic [4:0] ra[6] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14};
   logic [31:0] rv[6] = '{32'h2, 32'h12c, 32'h303, 32'h7878, 32'h100, 32'h0};
   muting_override #(.TICK_CYCLES(TK)) muting_override_i (.MCLK(mclk), .RST(rst), .ADDRESS(addr), .READ(rd),
      .WRITE(wr), .WRITEDATA(wdata), .READDATA(rdata), .WAITREQUEST(wait_req), .LC_IN1(lc1), .LC_IN2(lc2),
      .MS11(ms[0]), .MS12(ms[1]), .MS21(ms[2]), .MS22(ms[3]), .OVR_IN1(ov1), .OVR_IN2(ov2),
      .OUTPUT_ENABLE(oe), .MUTING_STATUS(mute), .OVERRIDE_STATUS(ovr), .SYNC_ERROR(sync_err),
      .SEQ_ERROR(seq_err), .LC_DISC_ERROR(lc_disc), .OVR_DISC_ERROR(ovr_disc), .FAULT_PRESENT(fault));
   lc_partner lc_partner_i (.clear(clear), .comp(comp), .lc_brk(lc_brk), .ovr_on(ovr_on), .ovr_brk(ovr_brk),
      .sens(sens), .lc1(lc1), .lc2(lc2), .ms(ms), .ov1(ov1), .ov2(ov2));
   // Clock
   initial begin
      mclk = 0;
      forever #5 mclk = ~mclk;
   end
   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // One bus access, held until wait is sampled low at a rising edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wait_req !== 1'b0 && n < 20);
      if (n >= 20) begin
         err_count++;
         stop_test();
      end
      got = rdata;
      rd <= 0;
      wr <= 0;
   endtask
   // Far-side levels, then a number of controller cycles
   task automatic pins(input logic [3:0] s, input logic c, input logic o, input int k);
      sens <= s;
      clear <= c;
      ovr_on <= o;
      repeat (k * TK) @(posedge mclk);
   endtask
   task automatic step(input logic [3:0] s, input logic c, input logic o, input int k, input logic [7:0] e);
      pins(s, c, o, k);
      @(negedge mclk);
      chk("outputs", {24'h0, e}, {24'h0, oe, mute, ovr, sync_err, seq_err, lc_disc, ovr_disc, fault});
      @(posedge mclk);
   endtask
   initial begin
      rst = 1;
      {rd, wr, addr, wdata, comp, lc_brk, ovr_on, ovr_brk, sens} = '0;
      clear = 1;
      err_count = 0;
      samples_checked = 0;
      repeat (6) @(posedge mclk);
      rst <= 0;
      // Reset values, unmapped place, read-only status
      foreach (ra[i]) begin
         bus(0, ra[i], 0);
         chk("register", rv[i], got);
      end
      bus(1, 5'h10, 32'hff);
      bus(0, 5'h10, 0);
      chk("status", 32'h100, got);
      bus(1, 5'h04, 32'h5);
      bus(1, 5'h0c, 32'h101);
      bus(1, 5'h00, 32'h3);
      step(0, 1, 0, 4, 8'h80);
      bus(0, 5'h10, 0);
      chk("status", 32'h201, got);
      // Parallel muting, then late and out-of-order sensors
      pins(1, 1, 0, 2);
      step(3, 1, 0, 4, 8'hc0);
      step(3, 0, 0, 4, 8'hc0);
      step(2, 0, 0, 4, 8'h00);
      step(0, 1, 0, 4, 8'h80);
      pins(1, 1, 0, 8);
      step(3, 1, 0, 4, 8'h90);
      step(0, 0, 0, 4, 8'h11);
      step(0, 1, 0, 4, 8'h90);
      step(2, 1, 0, 4, 8'h98);
      step(0, 0, 0, 4, 8'h19);
      pins(0, 1, 0, 4);
      pins(1, 1, 0, 2);
      step(3, 1, 0, 4, 8'hc0);
      step(0, 1, 0, 4, 8'h80);
      // Muting cut by its maximum time
      pins(1, 1, 0, 2);
      step(3, 1, 0, 54, 8'h80);
      step(0, 1, 0, 4, 8'h80);
      // Override, single input, armed only after seen off
      bus(1, 5'h00, 32'h12);
      pins(1, 0, 1, 2);
      bus(1, 5'h00, 32'h13);
      step(1, 0, 1, 4, 8'h00);
      pins(1, 0, 0, 4);
      step(1, 0, 1, 4, 8'he0);
      step(1, 0, 0, 4, 8'h00);
      step(1, 0, 1, 4, 8'he0);
      step(0, 0, 1, 4, 8'h00);
      pins(1, 0, 0, 4);
      pins(1, 0, 1, 0);
      for (n = 0; ovr !== 1'b1 && n < 100; n++) @(negedge mclk);
      for (n = 0; ovr === 1'b1 && n < 400; n++) @(negedge mclk);
      chk("override span ok", 32'h1, 32'(n >= 192 && n <= 212));
      @(posedge mclk);
      pins(0, 1, 0, 4);
      // Position detection, then both sequential modes
      bus(1, 5'h00, 32'h01);
      step(2, 1, 0, 4, 8'h80);
      step(3, 1, 0, 4, 8'hc0);
      step(0, 1, 0, 4, 8'h80);
      for (int m = 5; m <= 7; m += 2) begin
         bus(1, 5'h00, 32'(m));
         pins(1, 1, 0, 2);
         step(3, 1, 0, 4, 8'hc0);
         step(0, 1, 0, 4, 8'h80);
      end
      pins(8, 1, 0, 2);
      step(12, 1, 0, 4, 8'hc0);
      step(0, 1, 0, 4, 8'h80);
      pins(8, 1, 0, 8);
      step(12, 1, 0, 4, 8'h90);
      // Run restart, complementary curtain, discrepancies
      bus(1, 5'h00, 32'h0a);
      comp <= 1;
      bus(1, 5'h00, 32'h0b);
      step(0, 1, 0, 4, 8'h80);
      lc_brk <= 1;
      step(0, 1, 0, 6, 8'h05);
      lc_brk <= 0;
      step(0, 0, 0, 4, 8'h05);
      step(0, 1, 0, 4, 8'h80);
      bus(1, 5'h00, 32'h22);
      comp <= 0;
      bus(1, 5'h00, 32'h23);
      ovr_brk <= 1;
      step(0, 1, 0, 6, 8'h03);
      ovr_brk <= 0;
      step(0, 1, 1, 4, 8'h80);
      stop_test();
   end
endmodule
bind muting_override muting_override_asserts #(.TICK_CYCLES(TICK_CYCLES)) muting_override_asserts_i (
   .MCLK(MCLK), .RST(RST), .READ(READ), .WRITE(WRITE), .WAITREQUEST(WAITREQUEST), .LC_IN1(LC_IN1),
   .MS11(MS11), .MS12(MS12), .MS21(MS21), .MS22(MS22), .OVR_IN1(OVR_IN1), .OUTPUT_ENABLE(OUTPUT_ENABLE),
   .MUTING_STATUS(MUTING_STATUS), .OVERRIDE_STATUS(OVERRIDE_STATUS), .LC_DISC_ERROR(LC_DISC_ERROR),
   .OVR_DISC_ERROR(OVR_DISC_ERROR), .FAULT_PRESENT(FAULT_PRESENT));
